// >>> inc/ext_bus_defs.svh
// constants and the plain-words summary for the external bus unit
// How it works
// - 24-bit address, 16-bit data bus; byte, word and long operands.
// - port width decided every cycle; narrow port gets extra cycles.
// - address of (most significant) byte driven at start, held with strobe.
// - address strobe falls half a clock after the cycle starts.
// - read data captured on the cycle's last rising clock edge.
// - writes drive all sixteen data lines regardless of sizes.
// - write data driven half a clock after address strobe.
// - read: data strobe asserted together with address strobe.
// - write: data strobe one full clock after address strobe.
// - direction changes only at cycle start, only on read/write swap.
// - size code: 01 byte, 10 word, 11 three bytes, 00 long.
// - address space code output, valid while address strobe is low.
// - size acknowledge ends cycle; read latches data, write confirms store.
// - acknowledge 11 waits, 10 eight-bit, 01 sixteen-bit, 00 reserved.
// - internal chip-select acknowledges accepted like external ones.
// - bus fault ends an unterminated cycle, may come with acknowledge.
// - internal monitor raises bus fault; external master supplies its own.
// - halted: data floats, strobes inactive, address and codes held.
// - halt stalls only external cycles; interrupts not serviced when halted.
// - autovector only ends interrupt acknowledge; off under external master.
// - autovector held low autovectors every external interrupt.
// - 16-bit port on all lanes, 8-bit port on upper lanes.
// - multi-byte operands go most significant part first.
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH
`define SIZE_BYTE       2'b01
`define SIZE_WORD       2'b10
`define SIZE_THREE      2'b11
`define SIZE_LONG       2'b00
`define ACK_WAIT        2'b11
`define ACK_PORT8       2'b10
`define ACK_PORT16      2'b01
`define SPACE_CPU       3'b111
`define MONITOR_CYCLES  16'h0040
`endif

// >>> inc/ext_bus_pkg.sv
// types for the external bus unit
package ext_bus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_WAIT,
        ST_END,
        ST_HALT
    } bus_state_e;
endpackage

// >>> design/external_bus_unit.sv
// master side of the asynchronous external bus with dynamic sizing
`timescale 1ns/1ps
`include "ext_bus_defs.svh"

module external_bus_unit
    import ext_bus_pkg::*;
#(
    parameter int MONITOR_LIMIT = 64
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // internal request side
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_size,
    input  wire logic [2:0]  req_space,
    input  wire logic [23:0] req_addr,
    input  wire logic [31:0] req_wdata,
    input  wire logic        req_intack,
    input  wire logic        ext_master,
    input  wire logic        cs_ack_valid,
    input  wire logic [1:0]  cs_ack_code,
    output logic             done,
    output logic             fault,
    output logic             autovec,
    output logic [31:0]      rdata,
    output logic             halted,
    // external pins
    output logic [23:0]      address,
    output logic             address_strobe_n,
    output logic             data_strobe_n,
    output logic             read_write,
    output logic [1:0]       transfer_size_code,
    output logic [2:0]       address_space_code,
    input  wire logic [15:0] data_in,
    output logic [15:0]      data_out,
    output logic             data_oe,
    input  wire logic [1:0]  size_ack_n,
    input  wire logic        bus_fault_n,
    input  wire logic        halt_n,
    input  wire logic        auto_vector_request_n
);

    // ==========================================
    // reset release and input synchronisers
    logic       rst_s1;
    logic       rst_q;
    logic [4:0] sync1;
    logic [4:0] sync2;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1 <= 1'b0;
            rst_q  <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_q  <= rst_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            sync1 <= 5'h1f;
            sync2 <= 5'h1f;
        end
        else
        begin
            sync1 <= {size_ack_n, bus_fault_n, halt_n,
                      auto_vector_request_n};
            sync2 <= sync1;
        end
    end

    wire [1:0] ack_n_s = sync2[4:3];
    wire       bfault_s = ~sync2[2];
    wire       halt_s = ~sync2[1];
    wire       auto_vector_request_n_s = ~sync2[0];

    // ==========================================
    // cycle state
    bus_state_e  state;
    bus_state_e  next_state;
    logic [1:0]  remain;
    logic [23:0] cur_addr;
    logic [31:0] wbuf;
    logic        is_write;
    logic        intack;
    logic [15:0] mon_cnt;
    logic        as_fall;
    logic        ds_fall;
    logic        retry;
    logic        more_q;
    logic        term_fault_q;
    logic        auto_vector_request_n_q;

    // acknowledge from pins or from chip selects
    wire [1:0] ack_code = cs_ack_valid ? cs_ack_code : ack_n_s;
    wire ack8 = (ack_code == `ACK_PORT8);
    wire ack16 = (ack_code == `ACK_PORT16);
    wire auto_vector_request_n_ok = auto_vector_request_n_s && intack && !ext_master;
    wire mon_fault = (mon_cnt >= 16'(MONITOR_LIMIT)) && !ext_master;
    wire term_fault = bfault_s || mon_fault;
    wire term = ack8 || ack16 || auto_vector_request_n_ok || term_fault;

    // bytes moved this cycle from remaining count, port and alignment
    wire odd = cur_addr[0];
    wire [2:0] rem_bytes = (remain == `SIZE_LONG) ? 3'd4 : {1'b0, remain};
    wire [2:0] moved = ack8 || odd || rem_bytes == 3'd1 ? 3'd1 : 3'd2;
    wire [2:0] left = rem_bytes - moved;
    wire more = !term_fault && !auto_vector_request_n_ok && (left != 3'd0);

    // lane routing: 8-bit port and odd byte use upper or lower lane
    wire [7:0] rd_byte = (ack16 && odd) ? data_in[7:0] : data_in[15:8];
    wire [15:0] wr_word = wbuf[31:16];
    wire [15:0] wr_lanes = (rem_bytes == 3'd1 || odd) ?
                           {wr_word[15:8], wr_word[15:8]} : wr_word;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (req_valid && !halt_s)
                    next_state = ST_ADDR;
            // reads pass DATA too, so a stale synchronised acknowledge
            // from the previous cycle has drained before WAIT looks
            ST_ADDR:
                next_state = ST_DATA;
            ST_DATA:
                next_state = ST_WAIT;
            ST_WAIT:
                if (term)
                    next_state = ST_END;
            ST_END:
                if (halt_s && bfault_s)
                    next_state = ST_HALT;
                else if (halt_s)
                    next_state = ST_HALT;
                else if (more_q || retry)
                    next_state = ST_ADDR;
                else
                    next_state = ST_IDLE;
            ST_HALT:
                if (!halt_s)
                    next_state = (more_q || retry) ? ST_ADDR : ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // ==========================================
    // request capture, operand shifting and read assembly
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            remain   <= `SIZE_LONG;
            cur_addr <= 24'h00_0000;
            wbuf     <= 32'h0000_0000;
            is_write <= 1'b0;
            intack   <= 1'b0;
            rdata    <= 32'h0000_0000;
            retry    <= 1'b0;
        end
        else if (state == ST_IDLE && next_state == ST_ADDR)
        begin
            remain   <= req_size;
            cur_addr <= req_addr;
            is_write <= req_write;
            intack   <= req_intack;
            retry    <= 1'b0;
            rdata    <= 32'h0000_0000;
            case (req_size)
                `SIZE_BYTE: wbuf <= {req_wdata[7:0], 24'h00_0000};
                `SIZE_WORD: wbuf <= {req_wdata[15:0], 16'h0000};
                `SIZE_THREE: wbuf <= {req_wdata[23:0], 8'h00};
                default: wbuf <= req_wdata;
            endcase
        end
        else if (state == ST_WAIT && term)
        begin
            retry <= halt_s && bfault_s;
            if (!term_fault && !auto_vector_request_n_ok)
            begin
                if (!is_write)
                    rdata <= (moved == 3'd2) ? {rdata[15:0], data_in}
                                             : {rdata[23:0], rd_byte};
                wbuf     <= (moved == 3'd2) ? {wbuf[15:0], 16'h0000}
                                            : {wbuf[23:0], 8'h00};
                cur_addr <= cur_addr + 24'(moved);
                remain   <= (left == 3'd4) ? `SIZE_LONG : left[1:0];
            end
        end
    end

    // bus monitor counts cycles while waiting for a termination
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
            mon_cnt <= 16'h0000;
        else if (state == ST_WAIT && !term)
            mon_cnt <= mon_cnt + 16'h0001;
        else
            mon_cnt <= 16'h0000;
    end

    // ==========================================
    // pins: strobes change on the falling edge, half a clock into a state
    wire as_set = (state == ST_ADDR) || (state == ST_DATA) ||
                  (state == ST_WAIT);
    wire ds_set = is_write ? (state == ST_DATA || state == ST_WAIT)
                           : as_set;
    wire oe_set = is_write && (state == ST_DATA || state == ST_WAIT);

    always_ff @(negedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            as_fall <= 1'b0;
            ds_fall <= 1'b0;
        end
        else
        begin
            as_fall <= as_set;
            ds_fall <= ds_set;
        end
    end

    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            address            <= 24'h00_0000;
            read_write         <= 1'b1;
            transfer_size_code <= `SIZE_LONG;
            address_space_code <= 3'b000;
            data_out           <= 16'h0000;
        end
        else if (state == ST_IDLE && next_state == ST_ADDR)
        begin
            address            <= req_addr;
            read_write         <= !req_write;
            transfer_size_code <= req_size;
            address_space_code <= req_space;
        end
        else if (next_state == ST_ADDR)
        begin
            address            <= cur_addr;
            transfer_size_code <= remain;
        end
        else if (state == ST_ADDR)
            data_out <= wr_lanes;
    end

    assign address_strobe_n = !as_fall;
    assign data_strobe_n    = !ds_fall;
    // enable follows the state, so data leads the write strobe by half
    assign data_oe          = oe_set;
    assign req_ready        = (state == ST_IDLE) && !halt_s;
    assign done    = (state == ST_END) && !more_q && !term_fault_q
                     && !auto_vector_request_n_q;
    assign fault   = (state == ST_END) && term_fault_q && !retry;
    assign autovec = (state == ST_END) && auto_vector_request_n_q;
    // halted means the bus stands still, not a cycle still finishing
    assign halted  = (state == ST_HALT) || (state == ST_IDLE && halt_s);

    // termination kind held into the end state; remain wraps to the long
    // code after the last byte, so the continue decision is kept here
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            term_fault_q <= 1'b0;
            auto_vector_request_n_q       <= 1'b0;
            more_q       <= 1'b0;
        end
        else if (state == ST_WAIT && term)
        begin
            term_fault_q <= term_fault;
            auto_vector_request_n_q       <= auto_vector_request_n_ok && !term_fault;
            more_q       <= more;
        end
    end

endmodule

// >>> bench/external_bus_unit_monitor.sv
// pin-level timing checks for the external bus unit
`timescale 1ns/1ps
module external_bus_unit_monitor
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic [1:0]  req_size,
    input wire logic [2:0]  req_space,
    input wire logic [23:0] req_addr,
    input wire logic        halted,
    input wire logic [23:0] address,
    input wire logic        address_strobe_n,
    input wire logic        data_strobe_n,
    input wire logic        read_write,
    input wire logic [1:0]  transfer_size_code,
    input wire logic [2:0]  address_space_code,
    input wire logic        data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire take = req_valid && req_ready;
    // ==========================================================
    // strobes and codes
    chk_strobe_start:
        assert property (take |-> ##1 $fell(address_strobe_n))
        else $error("address strobe not on time");
    chk_read_pair:
        assert property ($fell(address_strobe_n) && read_write
            |-> $fell(data_strobe_n)) else $error("read strobe late");
    chk_write_data:
        assert property ($fell(address_strobe_n) && !read_write
            |-> data_strobe_n ##1 data_oe && $fell(data_strobe_n))
        else $error("write data or strobe mistimed");
    chk_cycle_codes:
        assert property (take |-> ##2 address == $past(req_addr, 2)
            && transfer_size_code == $past(req_size, 2)
            && address_space_code == $past(req_space, 2)
            && read_write == !$past(req_write, 2)) else $error("bad codes");
    chk_codes_hold:
        assert property (!address_strobe_n && !$past(address_strobe_n)
            |-> $stable({address, transfer_size_code, address_space_code,
            read_write})) else $error("codes moved under strobe");
    chk_write_drive:
        assert property (!data_strobe_n && !read_write |-> data_oe)
        else $error("write data not driven");
    chk_read_float:
        assert property (!address_strobe_n && read_write |-> !data_oe)
        else $error("data driven on read");
    chk_halt_quiet:
        assert property (halted && $past(halted) |-> address_strobe_n
            && data_strobe_n && !data_oe && !req_ready)
        else $error("bus active while halted");
endmodule

bind external_bus_unit external_bus_unit_monitor u_external_bus_unit_monitor
(
    .clk                (clk),
    .rst_n              (rst_n),
    .req_valid          (req_valid),
    .req_ready          (req_ready),
    .req_write          (req_write),
    .req_size           (req_size),
    .req_space          (req_space),
    .req_addr           (req_addr),
    .halted             (halted),
    .address            (address),
    .address_strobe_n   (address_strobe_n),
    .data_strobe_n      (data_strobe_n),
    .read_write         (read_write),
    .transfer_size_code (transfer_size_code),
    .address_space_code (address_space_code),
    .data_oe            (data_oe)
);

// >>> bench/bus_device_model.sv
// external memory on the parallel bus with selectable width and waits
`timescale 1ns/1ps
module bus_device_model
(
    input  wire logic        clk,
    input  wire logic [23:0] address,
    input  wire logic        address_strobe_n,
    input  wire logic        data_strobe_n,
    input  wire logic        read_write,
    input  wire logic [1:0]  transfer_size_code,
    input  wire logic [15:0] data_out,
    input  wire logic        port8,
    input  wire logic        mute,
    input  wire logic [1:0]  waits,
    output logic      [15:0] data_in,
    output logic      [1:0]  size_ack_n
);
    logic [7:0] mem [256];
    logic [7:0] a;
    int         cnt = 0;
    wire        wr = !read_write;
    assign a = address[7:0];
    initial data_in = 16'h0000;
    // ==========================================================
    // mute leaves a cycle unanswered; released lines keep toggling
    always @(posedge clk)
    begin
        cnt <= address_strobe_n ? 0 : cnt + 1;
        size_ack_n <= 2'b11;
        data_in <= ~data_in;
        if (!address_strobe_n && read_write)
            data_in <= port8 ? {mem[a], ~mem[a]} : a[0] ? {~mem[a], mem[a]}
                : {mem[a], mem[a + 8'd1]};
        if (!address_strobe_n && !mute && cnt >= waits
            && (read_write || !data_strobe_n))
        begin
            size_ack_n <= port8 ? 2'b10 : 2'b01;
            if (wr && (port8 || !a[0]))
                mem[a] <= data_out[15:8];
            if (wr && !port8 && a[0])
                mem[a] <= data_out[7:0];
            if (wr && !port8 && !a[0] && transfer_size_code != 2'b01)
                mem[a + 8'd1] <= data_out[7:0];
        end
    end
endmodule

// >>> bench/external_bus_unit_tb.sv
// self-checking bench for the external bus unit with a memory model
`timescale 1ns/1ps
module external_bus_unit_tb;
    logic        clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
    logic        req_intack = 0, ext_master = 0, cs_ack_valid = 0;
    logic        halt_n = 1, bus_fault_n = 1, auto_vector_request_n = 1;
    logic        port8 = 0, mute = 0;
    logic [1:0]  req_size = 2'b01, cs_ack_code = 2'b11, waits = 0;
    logic [2:0]  req_space = 3'b001;
    logic [23:0] req_addr = '0;
    logic [31:0] req_wdata = '0;
    wire         req_ready, done, fault, autovec, halted, data_oe;
    wire         address_strobe_n, data_strobe_n, read_write;
    wire  [31:0] rdata;
    wire  [23:0] address;
    wire  [15:0] data_in, data_out;
    wire  [1:0]  size_ack_n, transfer_size_code;
    wire  [2:0]  address_space_code;
    logic [7:0]  refm [256];
    logic [1:0]  sz [3] = '{2'b01, 2'b10, 2'b00};
    logic [2:0]  sp [5] = '{3'b001, 3'b010, 3'b101, 3'b110, 3'b111};
    int          n_errors = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    external_bus_unit #(.MONITOR_LIMIT(8)) u_external_bus_unit
    (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .req_valid             (req_valid),
        .req_ready             (req_ready),
        .req_write             (req_write),
        .req_size              (req_size),
        .req_space             (req_space),
        .req_addr              (req_addr),
        .req_wdata             (req_wdata),
        .req_intack            (req_intack),
        .ext_master            (ext_master),
        .cs_ack_valid          (cs_ack_valid),
        .cs_ack_code           (cs_ack_code),
        .done                  (done),
        .fault                 (fault),
        .autovec               (autovec),
        .rdata                 (rdata),
        .halted                (halted),
        .address               (address),
        .address_strobe_n      (address_strobe_n),
        .data_strobe_n         (data_strobe_n),
        .read_write            (read_write),
        .transfer_size_code    (transfer_size_code),
        .address_space_code    (address_space_code),
        .data_in               (data_in),
        .data_out              (data_out),
        .data_oe               (data_oe),
        .size_ack_n            (size_ack_n),
        .bus_fault_n           (bus_fault_n),
        .halt_n                (halt_n),
        .auto_vector_request_n (auto_vector_request_n)
    );
    bus_device_model u_bus_device_model
    (
        .clk                (clk),
        .address            (address),
        .address_strobe_n   (address_strobe_n),
        .data_strobe_n      (data_strobe_n),
        .read_write         (read_write),
        .transfer_size_code (transfer_size_code),
        .data_out           (data_out),
        .port8              (port8),
        .mute               (mute),
        .waits              (waits),
        .data_in            (data_in),
        .size_ack_n         (size_ack_n)
    );
    // ==========================================================
    // transfer and compare helpers
    task automatic check(input logic [31:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // r returns {autovec, fault, done}, zero when nothing ended the op
    task automatic op(input logic w, input logic [1:0] s,
                      input logic [23:0] a, input logic [31:0] d,
                      output logic [2:0] r);
        int k;
        k = 0;
        @(posedge clk);
        req_write <= w;
        req_size <= s;
        req_addr <= a;
        req_wdata <= d;
        req_valid <= 1'b1;
        do @(negedge clk); while (req_ready !== 1'b1 && ++k < 200);
        @(posedge clk);
        req_valid <= 1'b0;
        r = 3'b000;
        for (k = 0; k < 300 && r === 3'b000; k++)
        begin
            @(negedge clk);
            r = {autovec, fault, done};
        end
        @(posedge clk);
    endtask
    initial
    begin
        logic [1:0]  s;
        logic [2:0]  r;
        logic [23:0] a;
        logic [31:0] d, e, m;
        int          n;
        void'($urandom(49569));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 30; i++)
        begin
            s = sz[i % 3];
            n = s == 2'b01 ? 1 : s == 2'b10 ? 2 : 4;
            a = 24'($urandom) & ~24'(n > 1);
            d = $urandom;
            m = n == 4 ? '1 : (32'h1 << (8 * n)) - 1;
            port8 <= 1'($urandom);
            waits <= 2'($urandom);
            req_space <= sp[i % 5];
            op(1'b1, s, a, d, r);
            check(r, 3'b001, "write end");
            for (int j = 0; j < n; j++)
                refm[8'(a + j)] = d[8 * (n - 1 - j) +: 8];
            port8 <= 1'($urandom);
            op(1'b0, s, a, '0, r);
            e = '0;
            for (int j = 0; j < n; j++)
                e = {e[23:0], refm[8'(a + j)]};
            check(r, 3'b001, "read end");
            check(rdata & m, e, "read data");
        end
        op(1'b1, 2'b01, 24'h10, 32'h5a, r);
        mute <= 1'b1;
        port8 <= 1'b0;
        cs_ack_valid <= 1'b1;
        cs_ack_code <= 2'b01;
        op(1'b0, 2'b01, 24'h10, '0, r);
        check({r, rdata[7:0]}, {3'b001, 8'h5a}, "chip select read");
        cs_ack_valid <= 1'b0;
        op(1'b0, 2'b01, 24'h10, '0, r);
        check(r, 3'b010, "monitor timeout");
        auto_vector_request_n <= 1'b0;
        op(1'b0, 2'b01, 24'h10, '0, r);
        check(r, 3'b010, "autovector ignored");
        req_intack <= 1'b1;
        op(1'b0, 2'b01, 24'h10, '0, r);
        check(r, 3'b100, "autovector end");
        ext_master <= 1'b1;
        cs_ack_valid <= 1'b1;
        op(1'b0, 2'b01, 24'h10, '0, r);
        check({r, rdata[7:0]}, {3'b001, 8'h5a}, "master no autovec");
        ext_master <= 1'b0;
        cs_ack_valid <= 1'b0;
        req_intack <= 1'b0;
        auto_vector_request_n <= 1'b1;
        bus_fault_n <= 1'b0;
        op(1'b0, 2'b01, 24'h10, '0, r);
        check(r, 3'b010, "bus fault end");
        bus_fault_n <= 1'b1;
        mute <= 1'b0;
        halt_n <= 1'b0;
        repeat (3) @(posedge clk);
        fork
            op(1'b1, 2'b01, 24'h11, 32'h3c, r);
            begin
                repeat (10) @(negedge clk);
                check({req_ready, halted}, 2'b01, "halt stall");
                @(posedge clk);
                halt_n <= 1'b1;
            end
        join
        check(r, 3'b001, "halt release");
        op(1'b0, 2'b01, 24'h11, '0, r);
        check({r, rdata[7:0]}, {3'b001, 8'h3c}, "after halt");
        report_and_stop();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
endmodule
